/* File: odc_pkg.sv */
// Package for the output divider configuration register slice.
// Assumes a 16-bit register word and a 7-bit register address from the serial port.
package odc_pkg;
    localparam logic [6:0] ADDR_RSVD_A = 7'h21;
    localparam logic [6:0] ADDR_DIV_EN = 7'h22;
    localparam logic [6:0] ADDR_SEG12 = 7'h23;
    localparam logic [6:0] ADDR_SELBUF = 7'h24;
    localparam logic [6:0] ADDR_PRESC = 7'h25;
    localparam logic [6:0] ADDR_INTEGER = 7'h26;
    localparam logic [6:0] ADDR_DLY = 7'h27;
    localparam logic [6:0] ADDR_DEN_HI = 7'h28;
    localparam logic [6:0] ADDR_DEN_LO = 7'h29;
    localparam logic [6:0] ADDR_NUM_HI = 7'h2C;
    localparam logic [6:0] ADDR_NUM_LO = 7'h2D;
    // Field positions.
    localparam int EN_BIT = 5;
    localparam int SEG2_LSB = 9;
    localparam int SEG3_EN_BIT = 8;
    localparam int SEG2_EN_BIT = 7;
    localparam int SEG1_RATIO_BIT = 2;
    localparam int SEG1_EN_BIT = 1;
    localparam int DISTB_BIT = 11;
    localparam int DISTA_BIT = 10;
    localparam int SEL_LSB = 4;
    localparam int SEG3_LSB = 0;
    localparam int PRE_BIT = 12;
    localparam int NINT_LSB = 1;
    localparam int DLY_LSB = 8;
    // Reset values; unnamed bits reset to zero.
    localparam logic [15:0] RST_RSVD_A = 16'h0000;
    localparam logic [15:0] RST_DIV_EN = 16'h0020;
    localparam logic [15:0] RST_SEG12 = 16'h0204;
    localparam logic [15:0] RST_SELBUF = 16'h0411;
    localparam logic [15:0] RST_PRESC = 16'h0000;
    localparam logic [15:0] RST_INTEGER = 16'h0036;
    localparam logic [15:0] RST_DLY = 16'h0200;
    localparam logic [15:0] RST_DEN = 16'h03E8;
    localparam logic [15:0] RST_NUM = 16'h0000;
    typedef struct packed {
        logic [15:0] rsvd_a;
        logic [15:0] div_en;
        logic [15:0] seg12;
        logic [15:0] selbuf;
        logic [15:0] presc;
        logic [15:0] integer_w;
        logic [15:0] dly;
        logic [15:0] den_hi;
        logic [15:0] den_lo;
        logic [15:0] num_hi;
        logic [15:0] num_lo;
        logic [15:0] rdata;
    } odc_state_t;
endpackage

/* File: odc_regs.sv */
// Output divider and feedback divider configuration registers.
// Assumes a serial-port front end delivering a one-cycle write strobe with address and data
// on i_clk_sys, and a read address whose data appears one cycle later.
`timescale 1ns/10ps
`default_nettype none
module odc_regs
    import odc_pkg::*;
(
    input wire logic i_clk_sys, // System clock, 100 MHz.
    input wire logic i_rst, // Synchronous reset, active high.
    input wire logic i_wr_en, // One-cycle register write strobe.
    input wire logic [6:0] i_addr, // Register address for read or write.
    input wire logic [15:0] i_wdata, // Write data.
    output logic [15:0] o_rdata, // Read data, one cycle after address.
    output logic o_div_enable, // Whole output divider powered up.
    output logic o_seg1_enable, // Segment one powered up.
    output logic o_seg2_enable, // Segment two powered up.
    output logic o_seg3_enable, // Segment three powered up.
    output logic [3:0] o_seg1_div, // Segment one divide ratio, 0 when off.
    output logic [3:0] o_seg2_div, // Segment two divide ratio, 0 when off.
    output logic [3:0] o_seg3_div, // Segment three divide ratio, 0 when off.
    output logic [1:0] o_chain_len, // Number of chained segments, 0 when off.
    output logic o_buf_a_enable, // Divider to output A buffer enable.
    output logic o_buf_b_enable, // Divider to output B buffer enable.
    output logic [2:0] o_prescale_div, // Feedback prescaler ratio, 2 or 4.
    output logic [11:0] o_feedback_int, // Feedback divider integer part.
    output logic [4:0] o_detector_delay, // Detector delay in cycles, 0 when unused.
    output logic [31:0] o_frac_den, // Fraction denominator.
    output logic [31:0] o_frac_num // Fraction numerator.
);
    odc_state_t st_r;
    odc_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Ratio decoder shared by segments two and three.
    function automatic logic [3:0] seg_ratio(input logic [3:0] code);
        logic [3:0] r;
        r = 4'h0;
        case (code)
            4'h8: r = 4'h8;
            4'h4: r = 4'h6;
            4'h2: r = 4'h4;
            4'h1: r = 4'h2;
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and read mux; the host keeps unnamed bits at default.
    always_comb begin
        st_nxt = st_r;
        if (i_wr_en) begin
            if (i_addr == ADDR_RSVD_A) begin
                st_nxt.rsvd_a = i_wdata;
            end else if (i_addr == ADDR_DIV_EN) begin
                st_nxt.div_en = i_wdata;
            end else if (i_addr == ADDR_SEG12) begin
                st_nxt.seg12 = i_wdata;
            end else if (i_addr == ADDR_SELBUF) begin
                st_nxt.selbuf = i_wdata;
            end else if (i_addr == ADDR_PRESC) begin
                st_nxt.presc = i_wdata;
            end else if (i_addr == ADDR_INTEGER) begin
                st_nxt.integer_w = i_wdata;
            end else if (i_addr == ADDR_DLY) begin
                st_nxt.dly = i_wdata;
            end else if (i_addr == ADDR_DEN_HI) begin
                st_nxt.den_hi = i_wdata;
            end else if (i_addr == ADDR_DEN_LO) begin
                st_nxt.den_lo = i_wdata;
            end else if (i_addr == ADDR_NUM_HI) begin
                st_nxt.num_hi = i_wdata;
            end else if (i_addr == ADDR_NUM_LO) begin
                st_nxt.num_lo = i_wdata;
            end
        end
        if (i_addr == ADDR_RSVD_A) begin
            st_nxt.rdata = st_r.rsvd_a;
        end else if (i_addr == ADDR_DIV_EN) begin
            st_nxt.rdata = st_r.div_en;
        end else if (i_addr == ADDR_SEG12) begin
            st_nxt.rdata = st_r.seg12;
        end else if (i_addr == ADDR_SELBUF) begin
            st_nxt.rdata = st_r.selbuf;
        end else if (i_addr == ADDR_PRESC) begin
            st_nxt.rdata = st_r.presc;
        end else if (i_addr == ADDR_INTEGER) begin
            st_nxt.rdata = st_r.integer_w;
        end else if (i_addr == ADDR_DLY) begin
            st_nxt.rdata = st_r.dly;
        end else if (i_addr == ADDR_DEN_HI) begin
            st_nxt.rdata = st_r.den_hi;
        end else if (i_addr == ADDR_DEN_LO) begin
            st_nxt.rdata = st_r.den_lo;
        end else if (i_addr == ADDR_NUM_HI) begin
            st_nxt.rdata = st_r.num_hi;
        end else if (i_addr == ADDR_NUM_LO) begin
            st_nxt.rdata = st_r.num_lo;
        end else begin
            st_nxt.rdata = 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register with documented reset values.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_r <= '{RST_RSVD_A, RST_DIV_EN, RST_SEG12, RST_SELBUF, RST_PRESC, RST_INTEGER,
                      RST_DLY, RST_DEN, RST_DEN, RST_NUM, RST_NUM, 16'h0000};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded controls; a segment runs only with the divider and its own enable on.
    assign o_rdata = st_r.rdata;
    assign o_div_enable = st_r.div_en[EN_BIT];
    assign o_seg1_enable = o_div_enable && st_r.seg12[SEG1_EN_BIT];
    assign o_seg2_enable = o_div_enable && st_r.seg12[SEG2_EN_BIT];
    assign o_seg3_enable = o_div_enable && st_r.seg12[SEG3_EN_BIT];
    assign o_seg1_div = !o_seg1_enable ? 4'h0 : (st_r.seg12[SEG1_RATIO_BIT] ? 4'h3 : 4'h2);
    assign o_seg2_div = o_seg2_enable ? seg_ratio(st_r.seg12[SEG2_LSB +: 4]) : 4'h0;
    assign o_seg3_div = o_seg3_enable ? seg_ratio(st_r.selbuf[SEG3_LSB +: 4]) : 4'h0;

    // Chain length from the select field; unlisted codes power the chain down.
    always_comb begin
        o_chain_len = 2'h0;
        if (o_div_enable) begin
            case (st_r.selbuf[SEL_LSB +: 3])
                3'h4: o_chain_len = 2'h3;
                3'h2: o_chain_len = 2'h2;
                3'h1: o_chain_len = 2'h1;
                default: o_chain_len = 2'h0;
            endcase
        end
    end

    // Buffers, feedback divider and detector delay.
    assign o_buf_b_enable = st_r.selbuf[DISTB_BIT];
    assign o_buf_a_enable = st_r.selbuf[DISTA_BIT];
    assign o_prescale_div = st_r.presc[PRE_BIT] ? 3'h4 : 3'h2;
    assign o_feedback_int = st_r.integer_w[NINT_LSB +: 12];
    assign o_frac_den = {st_r.den_hi, st_r.den_lo};
    assign o_frac_num = {st_r.num_hi, st_r.num_lo};

    always_comb begin
        case (st_r.dly[DLY_LSB +: 6])
            6'h01: o_detector_delay = 5'h04;
            6'h02: o_detector_delay = 5'h06;
            6'h04: o_detector_delay = 5'h08;
            6'h08: o_detector_delay = 5'h0C;
            6'h10: o_detector_delay = 5'h10;
            default: o_detector_delay = 5'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on reset values and decode.
    AST_RST_DEFAULTS: assert property (@(posedge i_clk_sys) i_rst |=> (o_div_enable && o_buf_a_enable &&
        !o_buf_b_enable && o_feedback_int == 12'd27 && o_frac_den == 32'd65537000 && o_frac_num == 32'h0))
        else $error("Reset values wrong.");
    AST_SEG_OFF: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !st_r.seg12[SEG2_EN_BIT] |-> o_seg2_div == 4'h0) else $error("Segment two active while off.");
    AST_SEG2_SIX: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_seg2_enable && st_r.seg12[SEG2_LSB +: 4] == 4'h4) |-> o_seg2_div == 4'h6) else $error("Bad ratio.");
    AST_SEG1_RATIO: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_SEG12 && i_wdata[SEG1_EN_BIT] && o_div_enable) |=>
        o_seg1_div == ($past(i_wdata[SEG1_RATIO_BIT]) ? 4'h3 : 4'h2)) else $error("Bad seg1.");
    AST_CHAIN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_div_enable && st_r.selbuf[SEL_LSB +: 3] == 3'h4) |-> o_chain_len == 2'h3) else $error("Bad chain.");
    AST_BUF_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_SELBUF) |=> o_buf_b_enable == $past(i_wdata[DISTB_BIT]))
        else $error("Buffer B not updated.");
    AST_PRESC: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_PRESC && i_wdata[PRE_BIT]) |=> o_prescale_div == 3'h4)
        else $error("Prescaler wrong.");
    AST_DLY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_DLY && i_wdata[DLY_LSB +: 6] == 6'h08) |=> o_detector_delay == 5'h0C)
        else $error("Delay decode wrong.");
    AST_DLY_UNUSED: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_DLY && i_wdata[DLY_LSB +: 6] == 6'h20) |=> o_detector_delay == 5'h00)
        else $error("Unused delay code not idle.");
    AST_SEG3_EIGHT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_SELBUF && i_wdata[SEG3_LSB +: 4] == 4'h8 && o_seg3_enable) |=>
        o_seg3_div == 4'h8) else $error("Segment three ratio wrong.");
    // Powering the divider down must gate every segment and the chain at once.
    AST_DIV_OFF: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_DIV_EN && !i_wdata[EN_BIT]) |=> (!o_div_enable && !o_seg1_enable &&
        !o_seg2_enable && !o_seg3_enable && o_chain_len == 2'h0)) else $error("Divider not powered down.");
    // Buffer A, the integer and the wide fraction halves follow the word just written.
    AST_BUF_A_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_SELBUF) |=> o_buf_a_enable == $past(i_wdata[DISTA_BIT]))
        else $error("Buffer A not updated.");
    AST_INT_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_INTEGER) |=> o_feedback_int == $past(i_wdata[NINT_LSB +: 12]))
        else $error("Integer not updated.");
    AST_DEN_HI_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_DEN_HI) |=> o_frac_den[31:16] == $past(i_wdata))
        else $error("Upper denominator not updated.");
    AST_DEN_LO_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_DEN_LO) |=> o_frac_den[15:0] == $past(i_wdata))
        else $error("Lower denominator not updated.");
    AST_NUM_HI_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_NUM_HI) |=> o_frac_num[31:16] == $past(i_wdata))
        else $error("Upper numerator not updated.");
    AST_NUM_LO_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_wr_en && i_addr == ADDR_NUM_LO) |=> o_frac_num[15:0] == $past(i_wdata))
        else $error("Lower numerator not updated.");
    // Read data shows the register addressed one edge earlier, before any write at that edge.
    AST_READ_DEN_HI: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_addr == ADDR_DEN_HI) |=> o_rdata == $past(o_frac_den[31:16]))
        else $error("Read data wrong.");
endmodule
`default_nettype wire

/* File: odc_host_model.sv */
// Host model that programs the divider configuration registers.
// Assumes read data lags the sampled address by one clock, writes take one strobe cycle.
`timescale 1ns/10ps
`default_nettype none
module odc_host_model (
    input wire logic i_clk_sys, // System clock.
    input wire logic [15:0] i_rdata, // Read data from the slice.
    output logic o_wr_en, // Write strobe.
    output logic [6:0] o_addr, // Register address.
    output logic [15:0] o_wdata // Write data.
);
    // Idle port values at time zero.
    initial begin
        o_wr_en = 1'b0;
        o_addr = 7'h00;
        o_wdata = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////
    // One write; callers pass unnamed bits at their reset pattern.
    // Stale data is inverted so it never looks like a held value.
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        o_wr_en <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk_sys);
        o_wr_en <= 1'b0;
        o_wdata <= ~d;
        #1;
    endtask
    // One read; the address is driven at one edge, sampled at the next, data taken just after that edge.
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge i_clk_sys);
        o_addr <= a;
        @(posedge i_clk_sys);
        #1;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

/* File: output_divider_config_regs_tb.sv */
// Self-checking bench for the divider configuration registers.
// Assumes the host model drives the register port; assertions sit in the design.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module output_divider_config_regs_tb;
    import odc_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic wr_en, den_on, s1e, s2e, s3e, bufa, bufb;
    logic [6:0] addr;
    logic [15:0] wdata, rdata, d;
    logic [3:0] s1d, s2d, s3d;
    logic [1:0] chain;
    logic [2:0] pre;
    logic [11:0] nint;
    logic [4:0] dly;
    logic [31:0] den, num;
    int miscompares = 0;
    int n_compared = 0;
    logic [3:0] rc [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h3};
    logic [3:0] rv [6] = '{4'h8, 4'h6, 4'h4, 4'h2, 4'h0, 4'h0};
    logic [2:0] sc [6] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h3, 3'h4};
    logic [1:0] sl [6] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h3};
    logic [5:0] dc [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    logic [4:0] dv [6] = '{5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h00};
    logic [6:0] ra [12] = '{ADDR_RSVD_A, ADDR_DIV_EN, ADDR_SEG12, ADDR_SELBUF, ADDR_PRESC, ADDR_INTEGER,
        ADDR_DLY, ADDR_DEN_HI, ADDR_DEN_LO, ADDR_NUM_HI, ADDR_NUM_LO, 7'h30};
    logic [15:0] rr [12] = '{RST_RSVD_A, RST_DIV_EN, RST_SEG12, RST_SELBUF, RST_PRESC, RST_INTEGER,
        RST_DLY, RST_DEN, RST_DEN, RST_NUM, RST_NUM, 16'h0000};
    // Clock of 10 ns.
    always #5 i_clk_sys = ~i_clk_sys;
    ////////////////////////////////////////////////////////////////
    // Slice under test and the host that programs it.
    odc_regs dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wr_en(wr_en), .i_addr(addr), .i_wdata(wdata),
        .o_rdata(rdata), .o_div_enable(den_on), .o_seg1_enable(s1e), .o_seg2_enable(s2e), .o_seg3_enable(s3e),
        .o_seg1_div(s1d), .o_seg2_div(s2d), .o_seg3_div(s3d), .o_chain_len(chain), .o_buf_a_enable(bufa),
        .o_buf_b_enable(bufb), .o_prescale_div(pre), .o_feedback_int(nint), .o_detector_delay(dly),
        .o_frac_den(den), .o_frac_num(num));
    odc_host_model host (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .o_wr_en(wr_en), .o_addr(addr),
        .o_wdata(wdata));
    ////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops the run.
    task automatic wrap_up();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog far beyond the hundred or so cycles the tests need.
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
    // Main sequence: reset values, decodes, gating, wide halves, unmapped access.
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        #1;
        `CHK("reset controls", 10'h201, {den_on, s1e, s2e, s3e, s1d, chain})
        `CHK("reset buffers", 2'h1, {bufb, bufa})
        `CHK("reset feedback", {3'h2, 12'd27, 5'h06}, {pre, nint, dly})
        `CHK("reset fraction", {16'd1000, 16'd1000, 32'h0}, {den, num})
        for (int k = 0; k < 12; k++) begin
            host.rd(ra[k], d);
            `CHK("reset read", rr[k], d)
        end
        for (int k = 0; k < 6; k++) begin
            host.wr(ADDR_SEG12, {3'h0, rc[k], 9'h186});
            host.wr(ADDR_SELBUF, {5'h00, 1'b1, 3'h0, sc[k], rc[k]});
            `CHK("segment ratios", {rv[k], rv[k]}, {s2d, s3d})
            `CHK("chain", sl[k], chain)
            `CHK("segment one", 7'h73, {s1e, s2e, s3e, s1d})
        end
        host.wr(ADDR_SEG12, {3'h0, 4'h1, 9'h080});
        `CHK("only segment two", 11'h200, {s1e, s2e, s3e, s1d, s3d})
        host.wr(ADDR_SEG12, {3'h0, 4'h1, 9'h002});
        `CHK("segment one by two", 5'h12, {s1e, s1d})
        host.wr(ADDR_DIV_EN, 16'h0000);
        `CHK("divider off", 6'h00, {den_on, s1e, s2e, s3e, chain})
        host.wr(ADDR_DIV_EN, 16'h0020);
        `CHK("divider on", 2'h3, {den_on, s1e})
        host.wr(ADDR_SELBUF, 16'h0811);
        host.rd(ADDR_SELBUF, d);
        `CHK("buffers", {2'h2, 16'h0811}, {bufb, bufa, d})
        host.wr(ADDR_PRESC, 16'h1000);
        host.wr(ADDR_INTEGER, 16'h1FFE);
        `CHK("prescale and integer", {3'h4, 12'hFFF}, {pre, nint})
        for (int k = 0; k < 6; k++) begin
            host.wr(ADDR_DLY, {2'h0, dc[k], 8'h00});
            `CHK("delay", dv[k], dly)
        end
        host.wr(ADDR_DEN_HI, 16'hA5C3);
        host.wr(ADDR_DEN_LO, 16'h1234);
        host.wr(ADDR_NUM_HI, 16'h0F0E);
        host.wr(ADDR_NUM_LO, 16'h8001);
        host.wr(7'h30, 16'hFFFF);
        host.rd(7'h30, d);
        `CHK("fraction", {32'hA5C31234, 32'h0F0E8001, 16'h0}, {den, num, d})
        wrap_up();
    end
endmodule
`default_nettype wire
